// ### logic/cache_param_map.svh
// Offsets, field positions and encodings of the cache parameter answer words
`ifndef CACHE_PARAM_MAP_SVH
`define CACHE_PARAM_MAP_SVH
`define TYPE_LSB 0
`define TYPE_MSB 4
`define LEVEL_LSB 5
`define LEVEL_MSB 7
`define SELF_INIT_BIT 8
`define FULLY_ASSOC_BIT 9
`define RSVD_LSB 10
`define RSVD_MSB 13
`define SHARE_LSB 14
`define SHARE_MSB 25
`define CORES_LSB 26
`define CORES_MSB 31
`define LINE_LSB 0
`define LINE_MSB 11
`define PART_LSB 12
`define PART_MSB 21
`define WAYS_LSB 22
`define WAYS_MSB 31
`define TYPE_NULL 5'h00
`define TYPE_DATA 5'h01
`define TYPE_INSTR 5'h02
`define TYPE_UNIFIED 5'h03
`define LEGACY_LEAF_BIT 22
`define LEAF_LOW_LIMIT 32'h00000003
`define LEAF_EXT_BASE 32'h80000000
`define LEAF_CACHE_PARAM 32'h00000004
`define DESC_STRIDE_64 8'hf0
`define DESC_STRIDE_128 8'hf1
`define STRIDE_DEFAULT 8'h40
`define STRIDE_128 8'h80
`define STRIDE_LEGACY_NONE 8'h20
`endif

// ### logic/cache_param_pkg.sv
// Types for the cache parameter enumeration block
package cache_param_pkg;
    typedef struct packed {
        logic [4:0] cache_type;
        logic [2:0] level;
        logic self_init;
        logic fully_assoc;
        logic [11:0] share_m1;
        logic [5:0] cores_m1;
        logic [11:0] line_m1;
        logic [9:0] part_m1;
        logic [9:0] ways_m1;
        logic [31:0] sets_m1;
        logic [7:0] stride;
    } cache_desc_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ANSWER = 2'b01
    } query_state_t;
endpackage

// ### logic/cache_param_if.sv
// Index-to-descriptor lookup link between query logic and the table
`timescale 1ns/1ps
`default_nettype none
interface cache_param_if;
    logic [31:0] index;
    cache_param_pkg::cache_desc_t desc;
    modport query (output index, input desc);
    modport table_side (input index, output desc);
endinterface
`default_nettype wire

// ### logic/cache_desc_table.sv
// Constant per-level cache descriptor table
`timescale 1ns/1ps
`default_nettype none
`include "cache_param_map.svh"
module cache_desc_table #(
    parameter int NUM_LEVELS = 4
) (
    cache_param_if.table_side lk
);
    // A one-level table still needs a one-bit select
    localparam int IDX_W = (NUM_LEVELS > 1) ? $clog2(NUM_LEVELS) : 1;
    cache_param_pkg::cache_desc_t tbl [NUM_LEVELS];
    // Plain example geometry; each level is 32 KiB to 256 KiB
    for (genvar i = 0; i < NUM_LEVELS; i++) begin : g_level
        assign tbl[i].cache_type = (i == 1) ? `TYPE_INSTR
                                   : ((i == 0) ? `TYPE_DATA : `TYPE_UNIFIED);
        assign tbl[i].level = (i < 2) ? 3'h1 : 3'(i);
        assign tbl[i].self_init = 1'b1;
        assign tbl[i].fully_assoc = 1'b0;
        assign tbl[i].share_m1 = (i < 3) ? 12'h001 : 12'h007;
        assign tbl[i].cores_m1 = 6'h03;
        assign tbl[i].line_m1 = 12'h03f;
        assign tbl[i].part_m1 = 10'h000;
        assign tbl[i].ways_m1 = (i < 2) ? 10'h007 : 10'h00f;
        assign tbl[i].sets_m1 = (i < 2) ? 32'h0000003f : 32'h000000ff;
        assign tbl[i].stride = (i == 1) ? 8'h00 : `STRIDE_DEFAULT;
    end
    always_comb begin
        lk.desc = '0;
        if (lk.index < 32'(NUM_LEVELS)) begin
            lk.desc = tbl[lk.index[IDX_W-1:0]];
        end
    end
endmodule
`default_nettype wire

// ### logic/cache_parameter_enumeration.sv
// Answers the identification query for the cache parameter leaf
// How it works
// - Type in bits 4:0 (0 none,1 data,2 instr,3 unified); level from one.
// - Bit 8 marks self-initialising cache; bit 9 marks fully associative.
// - Bits 25:14 hold maximum logical processors sharing this cache, offset coded.
// - Bits 31:26 hold maximum cores per package minus one.
// - Second word bits 11:0 hold coherency line size in bytes minus one.
// - Second word bits 21:12 hold physical line partitions minus one.
// - Second word bits 31:22 hold ways of associativity minus one.
// - Third word is set count minus one; size is product of fields plus one.
// - Leaves above 3 below the extended base hidden while legacy bit set.
// - Report per-level prefetch stride used by the four prefetch hints.
// - Without the leaf, descriptor f0 means 64 bytes, f1 means 128.
`timescale 1ns/1ps
`default_nettype none
`include "cache_param_map.svh"
module cache_parameter_enumeration #(
    parameter int NUM_LEVELS = 4
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Query
    input wire logic i_query_valid,
    input wire logic [31:0] i_leaf,
    input wire logic [31:0] i_index,
    input wire logic [31:0] i_misc_enable,
    input wire logic [7:0] i_legacy_desc,
    // Answer
    output logic o_answer_valid,
    output logic [31:0] o_first_answer_word,
    output logic [31:0] o_second_answer_word,
    output logic [31:0] o_cache_set_count_word,
    output logic [31:0] o_reserved_answer_word,
    output logic o_leaf_visible,
    output logic [7:0] o_prefetch_stride,
    output logic o_stride_applies
);
    // The level field is three bits, so seven levels is the most it can name
    if (NUM_LEVELS < 1 || NUM_LEVELS > 7) begin : g_bad_levels
        $error("NUM_LEVELS must be 1..7");
    end

    cache_param_if lk ();
    cache_desc_table #(.NUM_LEVELS(NUM_LEVELS)) u_table (.lk(lk));

    cache_param_pkg::query_state_t state, next_state;
    logic answer_valid, next_answer_valid;
    logic [31:0] w0, next_w0;
    logic [31:0] w1, next_w1;
    logic [31:0] w2, next_w2;
    logic [31:0] w3, next_w3;
    logic visible, next_visible;
    logic [7:0] stride, next_stride;
    logic applies, next_applies;
    logic leaf_hidden;
    logic is_cache_leaf;

    assign lk.index = i_index;
    // Leaf hidden when the legacy limit bit is set and the leaf is in range
    assign leaf_hidden = i_misc_enable[`LEGACY_LEAF_BIT] && (i_leaf > `LEAF_LOW_LIMIT)
                         && (i_leaf < `LEAF_EXT_BASE);
    assign is_cache_leaf = (i_leaf == `LEAF_CACHE_PARAM) && !leaf_hidden;

    always_comb begin
        next_state = state;
        next_answer_valid = 1'b0;
        next_w0 = w0;
        next_w1 = w1;
        next_w2 = w2;
        next_w3 = '0;
        next_visible = visible;
        next_stride = stride;
        next_applies = applies;
        unique case (state)
            cache_param_pkg::ST_IDLE: begin
                if (i_query_valid) begin
                    next_state = cache_param_pkg::ST_ANSWER;
                    next_answer_valid = 1'b1;
                    next_visible = !leaf_hidden;
                    next_w0 = '0;
                    next_w1 = '0;
                    next_w2 = '0;
                    if (is_cache_leaf) begin
                        next_w0[`TYPE_MSB:`TYPE_LSB] = lk.desc.cache_type;
                        next_w0[`LEVEL_MSB:`LEVEL_LSB] = lk.desc.level;
                        next_w0[`SELF_INIT_BIT] = lk.desc.self_init;
                        next_w0[`FULLY_ASSOC_BIT] = lk.desc.fully_assoc;
                        next_w0[`SHARE_MSB:`SHARE_LSB] = lk.desc.share_m1;
                        next_w0[`CORES_MSB:`CORES_LSB] = lk.desc.cores_m1;
                        next_w1[`LINE_MSB:`LINE_LSB] = lk.desc.line_m1;
                        next_w1[`PART_MSB:`PART_LSB] = lk.desc.part_m1;
                        next_w1[`WAYS_MSB:`WAYS_LSB] = lk.desc.ways_m1;
                        next_w2 = lk.desc.sets_m1;
                        // Stride is kept apart from the line size on purpose
                        next_stride = (lk.desc.stride == 8'h00) ? `STRIDE_DEFAULT
                                      : lk.desc.stride;
                        next_applies = (lk.desc.cache_type == `TYPE_DATA) ||
                                       (lk.desc.cache_type == `TYPE_UNIFIED);
                    end else begin
                        // Legacy path when the query is not for the parameter leaf or that leaf is hidden
                        if (i_legacy_desc == `DESC_STRIDE_64) begin
                            next_stride = `STRIDE_DEFAULT;
                        end else if (i_legacy_desc == `DESC_STRIDE_128) begin
                            next_stride = `STRIDE_128;
                        end else begin
                            next_stride = `STRIDE_LEGACY_NONE;
                        end
                        next_applies = 1'b1;
                    end
                end
            end
            cache_param_pkg::ST_ANSWER: begin
                next_state = cache_param_pkg::ST_IDLE;
            end
            default: begin
                next_state = cache_param_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state <= cache_param_pkg::ST_IDLE;
            answer_valid <= 1'b0;
            w0 <= '0;
            w1 <= '0;
            w2 <= '0;
            w3 <= '0;
            visible <= 1'b0;
            stride <= 8'h00;
            applies <= 1'b0;
        end else begin
            state <= next_state;
            answer_valid <= next_answer_valid;
            w0 <= next_w0;
            w1 <= next_w1;
            w2 <= next_w2;
            w3 <= next_w3;
            visible <= next_visible;
            stride <= next_stride;
            applies <= next_applies;
        end
    end

    assign o_answer_valid = answer_valid;
    assign o_first_answer_word = w0;
    assign o_second_answer_word = w1;
    assign o_cache_set_count_word = w2;
    assign o_reserved_answer_word = w3;
    assign o_leaf_visible = visible;
    assign o_prefetch_stride = stride;
    assign o_stride_applies = applies;

    property p_reserved_zero;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_answer_valid |-> (o_first_answer_word[`RSVD_MSB:`RSVD_LSB] == 4'h0)
                           && (o_reserved_answer_word == 32'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

    property p_hidden_leaf;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && leaf_hidden)
        |=> (!o_leaf_visible && o_first_answer_word == 32'h0 && o_answer_valid);
    endproperty
    a_hidden_leaf: assert property (p_hidden_leaf) else $error("hidden leaf answered");

    property p_type_field;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && is_cache_leaf)
        |=> o_first_answer_word[`TYPE_MSB:`TYPE_LSB] == $past(lk.desc.cache_type);
    endproperty
    a_type_field: assert property (p_type_field) else $error("cache type wrong");

    property p_level_nonzero;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_answer_valid && o_first_answer_word[`TYPE_MSB:`TYPE_LSB] != `TYPE_NULL)
        |-> o_first_answer_word[`LEVEL_MSB:`LEVEL_LSB] != 3'h0;
    endproperty
    a_level_nonzero: assert property (p_level_nonzero) else $error("level zero");

    property p_flags;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && is_cache_leaf)
        |=> o_first_answer_word[`FULLY_ASSOC_BIT:`SELF_INIT_BIT]
            == $past({lk.desc.fully_assoc, lk.desc.self_init});
    endproperty
    a_flags: assert property (p_flags) else $error("flags wrong");

    property p_sharing;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && is_cache_leaf)
        |=> o_first_answer_word[`SHARE_MSB:`SHARE_LSB] == $past(lk.desc.share_m1)
            && o_first_answer_word[`CORES_MSB:`CORES_LSB] == $past(lk.desc.cores_m1);
    endproperty
    a_sharing: assert property (p_sharing) else $error("sharing counts wrong");

    property p_geometry;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && is_cache_leaf)
        |=> o_second_answer_word == $past({lk.desc.ways_m1, lk.desc.part_m1, lk.desc.line_m1})
            && o_cache_set_count_word == $past(lk.desc.sets_m1);
    endproperty
    a_geometry: assert property (p_geometry) else $error("geometry wrong");

    property p_stride_default;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && is_cache_leaf
         && lk.desc.stride == 8'h00) |=> o_prefetch_stride == `STRIDE_DEFAULT;
    endproperty
    a_stride_default: assert property (p_stride_default) else $error("default stride");

    property p_legacy_stride;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && !is_cache_leaf)
        |=> o_prefetch_stride == (($past(i_legacy_desc) == `DESC_STRIDE_64) ? `STRIDE_DEFAULT :
            (($past(i_legacy_desc) == `DESC_STRIDE_128) ? `STRIDE_128 : `STRIDE_LEGACY_NONE));
    endproperty
    a_legacy_stride: assert property (p_legacy_stride) else $error("legacy stride");

    property p_pulse;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_answer_valid |=> !o_answer_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("answer valid stuck");

    property p_stride_given;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && is_cache_leaf
         && lk.desc.stride != 8'h00) |=> o_prefetch_stride == $past(lk.desc.stride);
    endproperty
    a_stride_given: assert property (p_stride_given) else $error("given stride lost");

    property p_applies;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && is_cache_leaf)
        |=> o_stride_applies == ($past(lk.desc.cache_type) inside {`TYPE_DATA, `TYPE_UNIFIED});
    endproperty
    a_applies: assert property (p_applies) else $error("stride use flag wrong");

    property p_legacy_applies;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && !is_cache_leaf)
        |=> o_stride_applies;
    endproperty
    a_legacy_applies: assert property (p_legacy_applies) else $error("legacy flag");

    property p_legacy_words;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && !is_cache_leaf)
        |=> o_first_answer_word == 32'h0 && o_second_answer_word == 32'h0
            && o_cache_set_count_word == 32'h0;
    endproperty
    a_legacy_words: assert property (p_legacy_words) else $error("words not zero");

    property p_visible;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE)
        |=> o_leaf_visible == !$past(leaf_hidden);
    endproperty
    a_visible: assert property (p_visible) else $error("visibility wrong");

    property p_null_beyond;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE && is_cache_leaf
         && i_index >= 32'(NUM_LEVELS))
        |=> o_first_answer_word[`TYPE_MSB:`TYPE_LSB] == `TYPE_NULL;
    endproperty
    a_null_beyond: assert property (p_null_beyond) else $error("missing null type");

    property p_taken;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_query_valid && state == cache_param_pkg::ST_IDLE)
        |=> o_answer_valid;
    endproperty
    a_taken: assert property (p_taken) else $error("query not answered");

    property p_refused;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !(i_query_valid && state == cache_param_pkg::ST_IDLE)
        |=> !o_answer_valid;
    endproperty
    a_refused: assert property (p_refused) else $error("answer without query");

    property p_words_hold;
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        !o_answer_valid |-> $stable(o_first_answer_word) && $stable(o_second_answer_word)
            && $stable(o_cache_set_count_word) && $stable(o_prefetch_stride);
    endproperty
    a_words_hold: assert property (p_words_hold) else $error("answer changed early");

    c_data: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_answer_valid && o_first_answer_word[`TYPE_MSB:`TYPE_LSB] == `TYPE_DATA);
    c_null: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_answer_valid && o_leaf_visible && o_first_answer_word == 32'h0);
    c_hidden: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_answer_valid && !o_leaf_visible);
    c_legacy128: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_answer_valid && o_prefetch_stride == `STRIDE_128);
endmodule
`default_nettype wire

// ### verif/query_software.sv
// Software model that issues cache queries and interprets the answers
`timescale 1ns/1ps
`default_nettype none
module query_software (
    // Clock
    input wire logic i_clk_sys,
    // Query
    output logic o_query_valid,
    output logic [31:0] o_leaf,
    output logic [31:0] o_index,
    output logic [31:0] o_misc_enable,
    output logic [7:0] o_legacy_desc,
    // Answer
    input wire logic [31:0] i_first_answer_word,
    input wire logic [31:0] i_second_answer_word,
    input wire logic [31:0] i_cache_set_count_word
);
    initial begin
        o_query_valid = 1'b0;
        o_leaf = 32'h0;
        o_index = 32'h0;
        o_misc_enable = 32'h0;
        o_legacy_desc = 8'h0;
    end
    // With again set a second query follows at once; the device must drop it
    task automatic ask(input logic [31:0] leaf, input logic [31:0] idx,
            input logic [31:0] misc, input logic [7:0] desc, input bit again);
        @(posedge i_clk_sys);
        o_query_valid <= 1'b1;
        o_leaf <= leaf;
        o_index <= idx;
        o_misc_enable <= misc;
        o_legacy_desc <= desc;
        @(posedge i_clk_sys);
        o_query_valid <= again;
        if (again) begin
            o_leaf <= 32'h80000000;
        end
    endtask
    // Ends a second query that ask left standing, after the first answer is read
    task automatic drop();
        @(posedge i_clk_sys);
        o_query_valid <= 1'b0;
    endtask
    function automatic longint unsigned cache_bytes();
        return (longint'(i_second_answer_word[31:22]) + 1) *
            (longint'(i_second_answer_word[21:12]) + 1) *
            (longint'(i_second_answer_word[11:0]) + 1) *
            (longint'(i_cache_set_count_word) + 1);
    endfunction
    // Line size is never taken as the stride
    function automatic int stride_bytes(input bit has_leaf, input logic [7:0] field,
            input logic [7:0] desc);
        if (has_leaf) return (field == 8'h0) ? 64 : int'(field);
        if (desc == 8'hf0) return 64;
        if (desc == 8'hf1) return 128;
        return 32;
    endfunction
    function automatic bit stride_used(input logic [4:0] t);
        return t == 5'h1 || t == 5'h3;
    endfunction
    function automatic longint unsigned block_limit();
        return cache_bytes() / (longint'(i_first_answer_word[25:14]) + 1);
    endfunction
endmodule
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the cache parameter enumeration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end
module tb;
    localparam int NUM_LEVELS = 4;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_query_valid;
    logic [31:0] i_leaf;
    logic [31:0] i_index;
    logic [31:0] i_misc_enable;
    logic [7:0] i_legacy_desc;
    logic o_answer_valid;
    logic [31:0] o_first_answer_word;
    logic [31:0] o_second_answer_word;
    logic [31:0] o_cache_set_count_word;
    logic [31:0] o_reserved_answer_word;
    logic o_leaf_visible;
    logic [7:0] o_prefetch_stride;
    logic o_stride_applies;
    int n_errors = 0;
    int checks = 0;
    int n_answers = 0;
    int n_taken = 0;
    logic [31:0] rng = 32'h2;
    logic [31:0] r;
    logic [31:0] leaf;
    logic [31:0] misc;
    logic [7:0] desc;
    logic [7:0] descs [3] = '{8'hf0, 8'hf1, 8'h00};
    int exp_stride_q[$];
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) if (o_answer_valid === 1'b1) n_answers++;
    cache_parameter_enumeration #(.NUM_LEVELS(NUM_LEVELS)) DUT (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_query_valid(i_query_valid),
        .i_leaf(i_leaf), .i_index(i_index), .i_misc_enable(i_misc_enable),
        .i_legacy_desc(i_legacy_desc), .o_answer_valid(o_answer_valid),
        .o_first_answer_word(o_first_answer_word), .o_second_answer_word(o_second_answer_word),
        .o_cache_set_count_word(o_cache_set_count_word),
        .o_reserved_answer_word(o_reserved_answer_word), .o_leaf_visible(o_leaf_visible),
        .o_prefetch_stride(o_prefetch_stride), .o_stride_applies(o_stride_applies));
    query_software sw (
        .i_clk_sys(i_clk_sys), .o_query_valid(i_query_valid), .o_leaf(i_leaf),
        .o_index(i_index), .o_misc_enable(i_misc_enable), .o_legacy_desc(i_legacy_desc),
        .i_first_answer_word(o_first_answer_word), .i_second_answer_word(o_second_answer_word),
        .i_cache_set_count_word(o_cache_set_count_word));
    function automatic logic [31:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    task automatic tally_and_finish();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check_answer(input logic [31:0] lf, input logic [31:0] idx,
            input logic [31:0] ms, input logic [7:0] ds);
        logic vis;
        logic leaf4;
        logic [7:0] lstride;
        int t;
        longint unsigned size;
        vis = !(lf > 32'h3 && lf < 32'h80000000 && ms[22]);
        leaf4 = vis && lf == 32'h4;
        lstride = (ds == 8'hf0) ? 8'h40 : ((ds == 8'hf1) ? 8'h80 : 8'h20);
        `CHK(o_leaf_visible, vis)
        `CHK({o_reserved_answer_word, o_first_answer_word[13:10]}, 36'h0)
        exp_stride_q.push_back(sw.stride_bytes(leaf4, 8'h00, ds));
        `CHK(o_prefetch_stride, 8'(exp_stride_q.pop_front()))
        if (leaf4 && idx < NUM_LEVELS) begin
            t = (idx == 0) ? 1 : ((idx == 1) ? 2 : 3);
            size = (idx < 2) ? 64'd32768 : 64'd262144;
            `CHK(o_first_answer_word[31:14], {6'h03, (idx < 3) ? 12'h001 : 12'h007})
            `CHK(o_first_answer_word[9:8], 2'b01)
            `CHK(o_second_answer_word, (idx < 2) ? 32'h01c0003f : 32'h03c0003f)
            `CHK(o_cache_set_count_word, (idx < 2) ? 32'h0000003f : 32'h000000ff)
            `CHK(o_first_answer_word[4:0], 5'(t))
            `CHK(o_first_answer_word[7:5], (idx == 0) ? 3'h1 : 3'(idx))
            `CHK(o_stride_applies, t != 2)
            `CHK(sw.stride_used(o_first_answer_word[4:0]), o_stride_applies)
            `CHK(o_prefetch_stride == 8'h0, 1'b0)
            if (idx == 1) `CHK(o_prefetch_stride, 8'h40)
            `CHK(sw.cache_bytes(), size)
            `CHK(sw.block_limit(), size / ((idx < 3) ? 2 : 8))
        end else begin
            `CHK({o_first_answer_word, o_second_answer_word, o_cache_set_count_word}, 96'h0)
            `CHK(o_stride_applies, !leaf4)
            `CHK(o_prefetch_stride, leaf4 ? 8'h40 : lstride)
        end
    endtask
    task automatic run(input logic [31:0] lf, input logic [31:0] idx,
            input logic [31:0] ms, input logic [7:0] ds, input bit again);
        int k;
        sw.ask(lf, idx, ms, ds, again);
        n_taken++;
        k = 0;
        #1;
        while (o_answer_valid !== 1'b1 && k < 4) begin
            @(posedge i_clk_sys);
            #1;
            k++;
        end
        if (k == 4) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            tally_and_finish();
        end
        check_answer(lf, idx, ms, ds);
        if (again) begin
            sw.drop();
        end
    endtask
    initial begin
        repeat (8) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) run(32'h4, 32'(i), 32'h0, 8'h0, 1'b0);
        for (int i = 0; i < 3; i++) begin
            run(32'h4, 32'h2, 32'h00400000, descs[i], 1'b0);
            run(32'h5, 32'h0, 32'h0, descs[i], 1'b0);
        end
        run(32'h3, 32'h0, 32'h00400000, 8'hf1, 1'b0);
        run(32'h7fffffff, 32'h0, 32'h00400000, 8'hf0, 1'b0);
        run(32'h80000000, 32'h0, 32'h00400000, 8'h00, 1'b0);
        // Back-to-back query: the second one must vanish without an answer
        run(32'h4, 32'h0, 32'h0, 8'hf0, 1'b1);
        for (int i = 0; i < 40; i++) begin
            r = xorshift();
            misc = xorshift();
            desc = r[13] ? r[23:16] : (r[12] ? 8'hf1 : 8'hf0);
            leaf = r[1] ? 32'h4 : (r[0] ? {29'h10000000, r[4:2]} : {29'h0, r[4:2]});
            run(leaf, {29'h0, r[10:8]}, misc, desc, 1'b0);
        end
        repeat (3) @(posedge i_clk_sys);
        `CHK(n_answers, n_taken)
        tally_and_finish();
    end
endmodule
`default_nettype wire
